// [rtl/clock_ratio_pkg.sv]
/*
 Constants for the system clock ratio unit: register map, field layout,
 reset values, hard-coded reset options and timing counts.
 Assumes a 10 MHz register clock that stands in for the fastest internal clock.
*/
// Functional notes
// - System clock equals input times (1+div) times multiplier
// - Host mode: sync times (1+div) is input
// - Core clock multiplies system clock by core ratio
// - Config word loaded at reset or from option
// - Memory clock scaled, then halved for bus pins
// - Memory data moves at internal memory rate
// - Local bus clock scaled, then divided for pins
// - Local bus divider follows divide field
// - Local bus runs at half, quarter, eighth
// - Software may change unit ratios after reset
// - Ethernet, I2C, security, USB start at third
// - PCI and DMA full rate or off only
package clock_ratio_pkg;

    // ************************************************************
    // Register map
    // ************************************************************
    localparam logic [7:0] ADDR_CONFIG_WORD = 8'h00;
    localparam logic [7:0] ADDR_LB_CONFIG = 8'h04;
    localparam logic [7:0] ADDR_UNIT_RATIO = 8'h08;
    localparam logic [7:0] ADDR_STATUS = 8'h0C;
    localparam logic [7:0] ADDR_MULTIPLIERS = 8'h10;

    // ************************************************************
    // Field layout of the reset configuration word
    // ************************************************************
    localparam int LB_RATIO_BIT = 31;
    localparam int MEM_RATIO_BIT = 30;
    localparam int SYSTEM_PLL_MULTIPLIER_LSB = 24;
    localparam int SYSTEM_PLL_MULTIPLIER_W = 4;
    localparam int CORE_LSB = 16;
    localparam int CORE_W = 7;

    // Unit ratio codes and unit order
    localparam int NUM_UNITS = 6;
    localparam int UNIT_PCI_DMA = 5;
    localparam logic [1:0] RATIO_OFF = 2'h0;
    localparam logic [1:0] RATIO_FULL = 2'h1;
    localparam logic [1:0] RATIO_THIRD = 2'h3;
    localparam logic [11:0] UNIT_RATIO_RESET = 12'h7FF;
    localparam logic [1:0] LB_DIVIDE_RESET = 2'h0;

    // Hard-coded reset options; the values are arbitrary defaults
    localparam logic [31:0] HARD_OPTION [4] = '{
        32'h0404_0000, 32'h8404_0000, 32'h4304_0000, 32'hC204_0000};

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int CLOCK_NS = 100;
    localparam int PLL_LOCK_NS = 100000;
    localparam int PLL_LOCK_CYCLES = PLL_LOCK_NS / CLOCK_NS;
    localparam int STRAP_SETTLE = 3;

endpackage : clock_ratio_pkg

// [rtl/pll_lock_timer.sv]
/*
 Lock timer standing in for a PLL: reports lock a fixed time after start.
 Assumes start stays high while the lock is wanted.
*/
`timescale 1ns/1ps
module pll_lock_timer #(
    parameter int LOCK_CYCLES = 1000
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic start,
    output logic locked
);
    logic [15:0] count_reg;

    always_ff @(posedge aclk) begin
        if (!aresetn || !start) begin
            count_reg <= 16'h0;
        end else if (count_reg != 16'(LOCK_CYCLES)) begin
            count_reg <= count_reg + 16'h1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            locked <= 1'b0;
        end else begin
            locked <= start && (count_reg == 16'(LOCK_CYCLES));
        end
    end
endmodule : pll_lock_timer

// [rtl/system_clock_ratio_unit.sv]
/*
 System clock ratio unit: reset word capture, PLL lock sequencing, memory and
 local bus clock dividers, per-unit clock enables and an AXI4-Lite slave.
 Assumes aclk stands for the fastest internal clock; the system bus clock is
 modelled as every second aclk cycle, so ratio 1 of a 2x clock is every cycle.
*/
`timescale 1ns/1ps
module system_clock_ratio_unit #(
    parameter int LOCK_CYCLES = clock_ratio_pkg::PLL_LOCK_CYCLES
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [31:0] reset_config_word_low,
    input wire logic [2:0] reset_option_strap,
    input wire logic input_divide_strap,
    input wire logic pci_host_strap,
    input wire logic awvalid,
    output logic awready,
    input wire logic [7:0] awaddr,
    input wire logic [2:0] awprot,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    input wire logic arvalid,
    output logic arready,
    input wire logic [7:0] araddr,
    input wire logic [2:0] arprot,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic clocks_ready,
    output logic [15:0] csb_multiplier,
    output logic [15:0] primary_to_csb_multiplier,
    output logic [15:0] core_multiplier,
    output logic csb_clock_enable,
    output logic memory_bus_clock_out,
    output logic memory_bus_clock_out_n,
    output logic memory_data_strobe,
    output logic local_bus_clock_out,
    output logic local_bus_sync_out,
    output logic [5:0] unit_clock_enable
);
    typedef enum {ST_LOAD, ST_LOCK, ST_RUN} seq_state_t;

    // ************************************************************
    // Strap synchronisers
    // ************************************************************
    logic [36:0] strap_meta_reg;
    logic [36:0] strap_sync_reg;

    always_ff @(posedge aclk) begin
        strap_meta_reg <= {reset_config_word_low, reset_option_strap,
                           input_divide_strap, pci_host_strap};
        strap_sync_reg <= strap_meta_reg;
    end

    // ************************************************************
    // Reset sequence
    // ************************************************************
    seq_state_t state_reg;
    logic [1:0] settle_reg;
    logic [31:0] config_word_reg;
    logic divide_reg;
    logic host_reg;
    logic pll_locked;
    logic running;

    assign running = (state_reg == ST_RUN);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            settle_reg <= 2'h0;
        end else if (state_reg == ST_LOAD) begin
            settle_reg <= settle_reg + 2'h1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg <= ST_LOAD;
        end else begin
            case (state_reg)
                ST_LOAD: begin
                    if (settle_reg == 2'(clock_ratio_pkg::STRAP_SETTLE)) begin
                        state_reg <= ST_LOCK;
                    end
                end
                ST_LOCK: begin
                    if (pll_locked) begin
                        state_reg <= ST_RUN;
                    end
                end
                ST_RUN: state_reg <= ST_RUN;
                default: state_reg <= ST_LOAD;
            endcase
        end
    end

    // Word is caught once the straps have settled, never straight from the pins
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            config_word_reg <= 32'h0;
            divide_reg <= 1'b0;
            host_reg <= 1'b0;
        end else if (state_reg == ST_LOAD &&
                     settle_reg == 2'(clock_ratio_pkg::STRAP_SETTLE)) begin
            config_word_reg <= strap_sync_reg[4] ?
                clock_ratio_pkg::HARD_OPTION[strap_sync_reg[3:2]] :
                strap_sync_reg[36:5];
            divide_reg <= strap_sync_reg[1];
            host_reg <= strap_sync_reg[0];
        end
    end

    pll_lock_timer #(
        .LOCK_CYCLES(LOCK_CYCLES)
    ) u_lock (
        .aclk(aclk),
        .aresetn(aresetn),
        .start(state_reg == ST_LOCK || running),
        .locked(pll_locked)
    );

    // ************************************************************
    // Multipliers
    // ************************************************************
    logic [3:0] system_pll_multiplier;
    logic [6:0] core_ratio;
    logic [5:0] csb_mult;

    assign system_pll_multiplier = config_word_reg[clock_ratio_pkg::SYSTEM_PLL_MULTIPLIER_LSB +: clock_ratio_pkg::SYSTEM_PLL_MULTIPLIER_W];
    assign core_ratio = config_word_reg[clock_ratio_pkg::CORE_LSB +: clock_ratio_pkg::CORE_W];
    assign csb_mult = 6'({1'b0, divide_reg} + 2'h1) * 6'(system_pll_multiplier);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            csb_multiplier <= 16'h0;
            primary_to_csb_multiplier <= 16'h0;
            core_multiplier <= 16'h0;
        end else begin
            csb_multiplier <= 16'(csb_mult);
            // Host mode: sync input times (1+div) is the primary clock
            primary_to_csb_multiplier <= host_reg ? 16'(system_pll_multiplier) : 16'(csb_mult);
            core_multiplier <= 16'(csb_mult) * 16'(core_ratio);
        end
    end

    // ************************************************************
    // Clock ticks and bus clock dividers
    // ************************************************************
    logic phase_reg;
    logic csb_tick;
    logic mem_tick;
    logic lb_tick;
    logic [1:0] lb_divide_reg;
    logic [1:0] lb_count_reg;
    logic [1:0] lb_half;

    always_ff @(posedge aclk) begin
        if (!aresetn || !running) begin
            phase_reg <= 1'b0;
        end else begin
            phase_reg <= !phase_reg;
        end
    end

    assign csb_tick = running && phase_reg;
    assign mem_tick = running && (config_word_reg[clock_ratio_pkg::MEM_RATIO_BIT] || phase_reg);
    assign lb_tick = running && (config_word_reg[clock_ratio_pkg::LB_RATIO_BIT] || phase_reg);
    // Code 0,1,2 gives half, quarter, eighth; code 3 falls back to eighth
    assign lb_half = (lb_divide_reg == 2'h0) ? 2'h0 :
                     (lb_divide_reg == 2'h1) ? 2'h1 : 2'h3;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            csb_clock_enable <= 1'b0;
            memory_bus_clock_out <= 1'b0;
            memory_bus_clock_out_n <= 1'b1;
            memory_data_strobe <= 1'b0;
            clocks_ready <= 1'b0;
        end else begin
            csb_clock_enable <= csb_tick;
            clocks_ready <= running;
            memory_data_strobe <= mem_tick;
            if (mem_tick) begin
                memory_bus_clock_out <= !memory_bus_clock_out;
                memory_bus_clock_out_n <= memory_bus_clock_out;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn || !running) begin
            lb_count_reg <= 2'h0;
            local_bus_clock_out <= 1'b0;
            local_bus_sync_out <= 1'b0;
        end else if (lb_tick) begin
            if (lb_count_reg >= lb_half) begin
                lb_count_reg <= 2'h0;
                local_bus_clock_out <= !local_bus_clock_out;
                local_bus_sync_out <= !local_bus_clock_out;
            end else begin
                lb_count_reg <= lb_count_reg + 2'h1;
            end
        end
    end

    // ************************************************************
    // Unit clock enables
    // ************************************************************
    logic [11:0] unit_ratio_reg;

    genvar u;
    generate
        for (u = 0; u < clock_ratio_pkg::NUM_UNITS; u++) begin : g_unit
            unit_clock_divider u_div (
                .aclk(aclk),
                .aresetn(aresetn),
                .run(running),
                .tick_in(csb_tick),
                .ratio_sel(unit_ratio_reg[2*u +: 2]),
                .enable_out(unit_clock_enable[u])
            );
        end
    endgenerate

    // ************************************************************
    // AXI4-Lite slave
    // ************************************************************
    logic aw_full_reg;
    logic w_full_reg;
    logic [7:0] aw_addr_reg;
    logic [31:0] w_data_reg;
    logic [3:0] w_strb_reg;
    logic do_write;

    assign do_write = aw_full_reg && w_full_reg && !bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready <= 1'b0;
            aw_full_reg <= 1'b0;
            aw_addr_reg <= 8'h0;
        end else if (awvalid && awready) begin
            awready <= 1'b0;
            aw_full_reg <= 1'b1;
            aw_addr_reg <= awaddr;
        end else if (do_write) begin
            aw_full_reg <= 1'b0;
        end else if (!aw_full_reg && !bvalid) begin
            awready <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wready <= 1'b0;
            w_full_reg <= 1'b0;
            w_data_reg <= 32'h0;
            w_strb_reg <= 4'h0;
        end else if (wvalid && wready) begin
            wready <= 1'b0;
            w_full_reg <= 1'b1;
            w_data_reg <= wdata;
            w_strb_reg <= wstrb;
        end else if (do_write) begin
            w_full_reg <= 1'b0;
        end else if (!w_full_reg && !bvalid) begin
            wready <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid <= 1'b0;
            bresp <= 2'h0;
        end else if (do_write) begin
            bvalid <= 1'b1;
            bresp <= (aw_addr_reg == clock_ratio_pkg::ADDR_LB_CONFIG ||
                      aw_addr_reg == clock_ratio_pkg::ADDR_UNIT_RATIO) ? 2'h0 : 2'h2;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    // Ratio writes take effect only after the reset sequence has finished
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            unit_ratio_reg <= clock_ratio_pkg::UNIT_RATIO_RESET;
            lb_divide_reg <= clock_ratio_pkg::LB_DIVIDE_RESET;
        end else if (do_write && running && w_strb_reg[0]) begin
            if (aw_addr_reg == clock_ratio_pkg::ADDR_UNIT_RATIO) begin
                // PCI and DMA complex keeps only off or full rate
                unit_ratio_reg <= {1'b0, w_data_reg[10], w_data_reg[9:0]};
            end
            if (aw_addr_reg == clock_ratio_pkg::ADDR_LB_CONFIG) begin
                lb_divide_reg <= w_data_reg[1:0];
            end
        end
    end

    logic [31:0] read_word;

    always_comb begin
        read_word = 32'h0;
        case (araddr)
            clock_ratio_pkg::ADDR_CONFIG_WORD: read_word = config_word_reg;
            clock_ratio_pkg::ADDR_LB_CONFIG: read_word = {30'h0, lb_divide_reg};
            clock_ratio_pkg::ADDR_UNIT_RATIO: read_word = {20'h0, unit_ratio_reg};
            clock_ratio_pkg::ADDR_STATUS: read_word = {28'h0, host_reg, divide_reg,
                                                       pll_locked, running};
            clock_ratio_pkg::ADDR_MULTIPLIERS: read_word = {core_multiplier, csb_multiplier};
            default: read_word = 32'h0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b0;
            rvalid <= 1'b0;
            rdata <= 32'h0;
            rresp <= 2'h0;
        end else if (arvalid && arready) begin
            arready <= 1'b0;
            rvalid <= 1'b1;
            rdata <= read_word;
            rresp <= (araddr[1:0] != 2'h0 || araddr > clock_ratio_pkg::ADDR_MULTIPLIERS) ?
                     2'h2 : 2'h0;
        end else if (rvalid && rready) begin
            rvalid <= 1'b0;
        end else if (!rvalid) begin
            arready <= 1'b1;
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_csb_mult_value: assert property (
        ##1 csb_multiplier == 16'(($past(divide_reg) + 1) * $past(system_pll_multiplier)))
        else $error("system multiplier wrong");
    a_host_mult_value: assert property (
        host_reg && $stable(host_reg) && $stable(system_pll_multiplier) |=> primary_to_csb_multiplier == 16'(system_pll_multiplier))
        else $error("host multiplier wrong");
    a_core_mult_value: assert property (
        ($stable(config_word_reg) && $stable(divide_reg)) [*2] |->
        core_multiplier == csb_multiplier * 16'(core_ratio))
        else $error("core multiplier wrong");
    a_word_frozen: assert property (
        state_reg != ST_LOAD |=> $stable(config_word_reg))
        else $error("config word changed after load");
    a_mem_halved: assert property (
        mem_tick |=> memory_bus_clock_out != $past(memory_bus_clock_out)
        && memory_bus_clock_out_n == $past(memory_bus_clock_out))
        else $error("memory bus clock not halved");
    a_mem_strobe_rate: assert property (
        running && config_word_reg[clock_ratio_pkg::MEM_RATIO_BIT] ##1 running
        |-> memory_data_strobe)
        else $error("memory data strobe missing");
    a_lb_toggle_cause: assert property (
        running && $changed(local_bus_clock_out) |-> $past(lb_tick))
        else $error("local bus clock moved without tick");
    a_lb_divide_hold: assert property (
        lb_tick && lb_count_reg < lb_half |=> $stable(local_bus_clock_out))
        else $error("local bus divider ignored field");
    a_lb_half_rate: assert property (
        lb_divide_reg == 2'h0 && lb_tick && running
        ##1 lb_divide_reg == 2'h0 && lb_tick && running
        |=> $changed(local_bus_clock_out))
        else $error("local bus not at half rate");
    a_ratio_after_reset: assert property (
        !running |=> $stable(unit_ratio_reg))
        else $error("unit ratio changed during reset");
    a_unit_third_rate: assert property (
        unit_ratio_reg[1:0] == clock_ratio_pkg::RATIO_THIRD && unit_clock_enable[0]
        |-> ##1 (!unit_clock_enable[0] ||
                 unit_ratio_reg[1:0] != clock_ratio_pkg::RATIO_THIRD) [*4])
        else $error("first unit not at third rate");
    a_pci_no_divide: assert property (
        unit_ratio_reg[11] == 1'b0)
        else $error("pci unit divided");
    a_hold_until_lock: assert property (
        !running |=> !csb_clock_enable && !memory_data_strobe && unit_clock_enable == 6'h0)
        else $error("clock enabled before lock");
endmodule : system_clock_ratio_unit

// [rtl/unit_clock_divider.sv]
/*
 Per-unit clock enable divider: passes every first, second or third tick.
 Assumes tick_in is a one-cycle pulse on aclk.
*/
`timescale 1ns/1ps
module unit_clock_divider (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic run,
    input wire logic tick_in,
    input wire logic [1:0] ratio_sel,
    output logic enable_out
);
    logic [1:0] count_reg;

    always_ff @(posedge aclk) begin
        if (!aresetn || !run) begin
            count_reg <= 2'h0;
        end else if (tick_in) begin
            count_reg <= (count_reg >= ratio_sel - 2'h1) ? 2'h0 : count_reg + 2'h1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            enable_out <= 1'b0;
        end else begin
            enable_out <= run && tick_in && (count_reg == 2'h0) && (ratio_sel != 2'h0);
        end
    end
endmodule : unit_clock_divider

// [testbench/board_strap_model.sv]
/*
 Board-side strap source: reset word pins, option select, divide and host straps.
 Assumes the bench changes sel only while the block is held in reset.
*/
`timescale 1ns/1ps
module board_strap_model (
    input wire logic [1:0] sel,
    output logic [31:0] reset_config_word_low,
    output logic [2:0] reset_option_strap,
    output logic input_divide_strap,
    output logic pci_host_strap
);
    // ****************************************
    // Strap sets
    // ****************************************
    // Pin word is inverted when a hard option is chosen, so a block that
    // wrongly reads the pins shows other ratios
    always_comb begin
        reset_config_word_low = 32'h0305_0000;
        reset_option_strap = 3'h0;
        input_divide_strap = 1'h1;
        pci_host_strap = 1'h1;
        if (sel == 2'h1) begin
            reset_config_word_low = ~32'h0305_0000;
            reset_option_strap = 3'h7;
            input_divide_strap = 1'h0;
            pci_host_strap = 1'h0;
        end
    end
endmodule : board_strap_model

// [testbench/system_clock_ratio_unit_tb_top.sv]
/*
 Self-checking bench for the clock ratio unit: AXI4-Lite master tasks,
 pulse counters on the clock outputs, two reset runs with different straps.
 Assumes LOCK_CYCLES of 20 and a 10 MHz aclk.
*/
`timescale 1ns/1ps
module system_clock_ratio_unit_tb_top;
    // ****************************************
    // Signals and instances
    // ****************************************
    logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rd, rdata, reset_config_word_low;
    logic [1:0] sel = 2'h0, rs, bresp, rresp;
    logic [2:0] reset_option_strap;
    logic input_divide_strap, pci_host_strap, awready, wready, bvalid, arready, rvalid;
    logic clocks_ready, csb_clock_enable, memory_bus_clock_out, memory_bus_clock_out_n;
    logic memory_data_strobe, local_bus_clock_out, local_bus_sync_out;
    logic [15:0] csb_multiplier, primary_to_csb_multiplier, core_multiplier;
    logic [5:0] unit_clock_enable;
    int fails = 0, n_tests = 0, nce, nmb, nms, nlc, bad;
    int nue [6];

    // Board clock stands in for a primary input kept inside its legal range
    always #50 aclk = ~aclk;

    board_strap_model u_board_strap_model (.sel, .reset_config_word_low,
        .reset_option_strap, .input_divide_strap, .pci_host_strap);

    system_clock_ratio_unit #(.LOCK_CYCLES(20)) u_system_clock_ratio_unit (.aclk, .aresetn,
        .reset_config_word_low, .reset_option_strap, .input_divide_strap, .pci_host_strap,
        .awvalid, .awready, .awaddr, .awprot(3'h0), .wvalid, .wready, .wdata, .wstrb(4'hF),
        .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .arprot(3'h0), .rvalid,
        .rready, .rdata, .rresp, .clocks_ready, .csb_multiplier, .primary_to_csb_multiplier,
        .core_multiplier, .csb_clock_enable, .memory_bus_clock_out, .memory_bus_clock_out_n,
        .memory_data_strobe, .local_bus_clock_out, .local_bus_sync_out, .unit_clock_enable);

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : check

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : tally_and_finish

    task automatic timeout();
        fails++;
        tally_and_finish();
    endtask : timeout

    task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        logic ta, tw;
        ta = 0;
        tw = 0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        for (n = 0; n < 40; n++) begin
            @(posedge aclk);
            if (ta && tw && bvalid === 1'h1) break;
            if (awvalid && awready === 1'h1) begin
                ta = 1;
                awvalid <= 1'h0;
            end
            if (wvalid && wready === 1'h1) begin
                tw = 1;
                wvalid <= 1'h0;
            end
        end
        r = bresp;
        bready <= 1'h0;
        if (n == 40) timeout();
    endtask : axw

    task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        logic ta;
        ta = 0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        for (n = 0; n < 40; n++) begin
            @(posedge aclk);
            if (ta && rvalid === 1'h1) break;
            if (arvalid && arready === 1'h1) begin
                ta = 1;
                arvalid <= 1'h0;
            end
        end
        d = rdata;
        r = rresp;
        rready <= 1'h0;
        if (n == 40) timeout();
    endtask : axr

    // Counts pulses and edges over c cycles, sampled at each rising edge
    task automatic count(input int c);
        int i;
        logic pm, pl;
        nce = 0;
        nmb = 0;
        nms = 0;
        nlc = 0;
        bad = 0;
        for (i = 0; i < 6; i++) nue[i] = 0;
        @(posedge aclk);
        pm = memory_bus_clock_out;
        pl = local_bus_clock_out;
        repeat (c) begin
            @(posedge aclk);
            nce += (csb_clock_enable === 1'h1);
            nms += (memory_data_strobe === 1'h1);
            nmb += (memory_bus_clock_out !== pm);
            nlc += (local_bus_clock_out === 1'h1 && pl === 1'h0);
            bad += (memory_bus_clock_out_n !== ~memory_bus_clock_out);
            bad += (local_bus_sync_out !== local_bus_clock_out);
            for (i = 0; i < 6; i++) nue[i] += (unit_clock_enable[i] === 1'h1);
            pm = memory_bus_clock_out;
            pl = local_bus_clock_out;
        end
    endtask : count

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic wait_run();
        int n, b;
        b = 0;
        for (n = 0; n < 400; n++) begin
            @(posedge aclk);
            if (clocks_ready === 1'h1) break;
            if (n < 16) b += (unit_clock_enable !== 6'h00) || (csb_clock_enable !== 1'h0);
        end
        if (n == 400) timeout();
        check("held clocks", b, 0);
        repeat (4) @(posedge aclk);
        $display("lock wait done");
    endtask : wait_run

    task automatic t_ratios(input logic [31:0] w, input logic dv, input logic hs);
        int m, k;
        logic [1:0] r;
        m = (1 + dv) * w[27:24];
        check("csb mult", csb_multiplier, m);
        check("input mult", primary_to_csb_multiplier, hs ? w[27:24] : m);
        check("core mult", core_multiplier, m * w[22:16]);
        axr(clock_ratio_pkg::ADDR_CONFIG_WORD, rd, r);
        check("config word", rd, w);
        count(48);
        check("csb enable", nce, 24);
        check("mem strobe", nms, w[30] ? 48 : 24);
        check("mem clock", nmb, w[30] ? 48 : 24);
        for (k = 0; k < 4; k++) begin
            axw(clock_ratio_pkg::ADDR_LB_CONFIG, k, r);
            check("lb resp", r, 2'h0);
            repeat (40) @(posedge aclk);
            count(64);
            check("lb clock", nlc, (w[31] ? 32 : 16) >> (k == 3 ? 2 : k));
        end
        check("pair levels", bad, 0);
        $display("ratio test done");
    endtask : t_ratios

    task automatic t_units();
        int i;
        int e [6] = '{24, 8, 12, 24, 0, 0};
        logic [1:0] r;
        axr(clock_ratio_pkg::ADDR_UNIT_RATIO, rd, r);
        check("ratio reset", rd, clock_ratio_pkg::UNIT_RATIO_RESET);
        count(48);
        for (i = 0; i < 5; i++) check("unit third", nue[i], 8);
        check("pci full", nue[5], 24);
        axw(clock_ratio_pkg::ADDR_UNIT_RATIO, 32'h0000_0FFF, r);
        axr(clock_ratio_pkg::ADDR_UNIT_RATIO, rd, r);
        check("pci codes", rd, 32'h0000_07FF);
        // Security at half and USB at full or off keep those units slow
        axw(clock_ratio_pkg::ADDR_UNIT_RATIO, 32'h0000_006D, r);
        repeat (12) @(posedge aclk);
        count(48);
        for (i = 0; i < 6; i++) check("unit rate", nue[i], e[i]);
        axr(8'h14, rd, r);
        check("unmapped rd", r, 2'h2);
        axw(8'h14, 32'h1, r);
        check("unmapped wr", r, 2'h2);
        $display("unit test done");
    endtask : t_units

    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'h1;
        // Ratio writes before the clocks run must be ignored
        axw(clock_ratio_pkg::ADDR_UNIT_RATIO, 32'h0, rs);
        check("early write", rs, 2'h0);
        wait_run();
        t_ratios(32'h0305_0000, 1'h1, 1'h1);
        t_units();
        sel <= 2'h1;
        aresetn <= 1'h0;
        repeat (16) @(posedge aclk);
        aresetn <= 1'h1;
        wait_run();
        t_ratios(clock_ratio_pkg::HARD_OPTION[3], 1'h0, 1'h0);
        tally_and_finish();
    end
endmodule : system_clock_ratio_unit_tb_top
